// ---- core/rtcc_pkg.sv ----
// constants, field layouts and carrier types for the rtc control/status registers
package rtcc_pkg;

  // ==========================================================================
  // register select codes
  localparam logic [1:0] REG_OSC_RATE = 2'h0;
  localparam logic [1:0] REG_MODE     = 2'h1;
  localparam logic [1:0] REG_FLAGS    = 2'h2;
  localparam logic [1:0] REG_BATTERY  = 2'h3;

  // ==========================================================================
  // field positions and values
  localparam int         UPD_PEND_BIT   = 7;
  localparam int         OSC_LSB        = 4;
  localparam int         RATE_LSB       = 0;
  localparam logic [2:0] OSC_RUN_CODE   = 3'h2;
  localparam logic [1:0] OSC_HOLD_TOP   = 2'h3;
  localparam logic [3:0] RATE_NONE      = 4'h0;
  localparam logic [3:0] RATE_CODE_1    = 4'h1;
  localparam logic [3:0] RATE_CODE_2    = 4'h2;
  localparam logic [3:0] TAP_CODE_1     = 4'h6;
  localparam logic [3:0] TAP_CODE_2     = 4'h7;
  localparam logic [3:0] TAP_SHIFT      = 4'h2;
  localparam int         ALARM_ANY_BIT  = 7;
  localparam logic [3:0] FLAGS_UNUSED   = 4'h0;
  localparam logic [6:0] BATT_UNUSED    = 7'h00;
  localparam logic [7:0] RDATA_RESET    = 8'h00;

  // ==========================================================================
  // timing
  localparam int unsigned CORE_HZ       = 100000000;
  localparam int unsigned TB_RATE_HZ    = 32768;
  localparam int          DIV_STAGES    = 15;
  localparam int unsigned PEND_LEAD_US  = 244;
  localparam int unsigned FIRST_UPD_MS  = 500;
  // least time: round up to whole divider ticks
  localparam int unsigned PEND_LEAD_TICKS = (PEND_LEAD_US * TB_RATE_HZ + 999999) / 1000000;
  localparam int unsigned FIRST_UPD_TICKS = (FIRST_UPD_MS * TB_RATE_HZ) / 1000;
  localparam logic [DIV_STAGES-1:0] DIV_PRESET =
    DIV_STAGES'((1 << DIV_STAGES) - FIRST_UPD_TICKS);
  localparam logic [DIV_STAGES-1:0] DIV_LAST   = DIV_STAGES'((1 << DIV_STAGES) - 1);
  localparam logic [DIV_STAGES-1:0] DIV_PEND_AT =
    DIV_STAGES'((1 << DIV_STAGES) - PEND_LEAD_TICKS - 1);

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    OSC_OFF     = 2'b00,
    OSC_HELD    = 2'b01,
    OSC_RUNNING = 2'b10
  } rtcc_osc_e;

  typedef struct packed {
    logic [2:0] osc;
    logic [3:0] rate;
  } rtcc_ctrl_a_s;

  typedef struct packed {
    logic set_freeze;
    logic periodic_irq_enable;
    logic alarm_irq_enable;
    logic update_done_irq_enable;
    logic square_wave_enable;
    logic binary_format_sel;
    logic hour_24_sel;
    logic daylight_saving_enable;
  } rtcc_mode_s;

  typedef struct packed {
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } rtcc_time_s;

endpackage

// ---- core/rtcc_regs.sv ----
// control, status and flag registers of the real-time clock
// Functional notes
// [R1] update pending low guarantees 244us before transfer
// [R2] freeze write blocks transfer, clears pending bit
// [R3] oscillator: 010 run, 11x held, else off
// [R4] first update 500ms after run pattern
// [R5] rate code selects divider tap or none
// [R6] rate bits read/write, kept over pin reset
// [R7] user copy advances per second unless frozen
// [R8] freeze bit untouched by pin reset, hardware
// [R9] periodic enable gates flag onto interrupt
// [R10] alarm on hms match, top bit wildcard
// [R11] alarm enable gates alarm flag, reset clears
// [R12] update enable cleared by reset or freeze
// [R13] square wave toggles when enabled, else low
// [R14] format bit binary or bcd, reset-proof
// [R15] hour format bit 24h or 12h, reset-proof
// [R16] daylight saving spring jump 1:59:59 to 3:00
// [R17] daylight saving autumn 1:59:59 back to 1:00
// [R18] summary flag is or of gated flags
// [R19] periodic flag set on tap edge
// [R20] alarm flag set on match, read clears
// [R21] update done flag set every update
// [R22] unused flag and battery bits read zero
// [R23] battery bit read-only, shows cell state
// [R24] interrupt low while gated flag; read clears
// [R25] rate codes map to documented tap rates
// [R26] internal update runs every second while the oscillator runs, frozen or not
// [R27] battery bit comes from external input
module rtcc_regs
  import rtcc_pkg::*;
#(
  parameter int unsigned TB_INC = TB_RATE_HZ
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       rst_pin_n,
  input  wire logic       battery_good_pin,
  input  rtcc_time_s      cur_time,
  input  rtcc_time_s      alarm_time,
  output logic            irq_n,
  output logic            square_wave_out,
  output logic            internal_update,
  output logic            user_copy_update,
  output logic            binary_format_sel,
  output logic            hour_24_sel,
  output logic            daylight_saving_enable
);

  // ==========================================================================
  // state
  logic [26:0]           tb_acc;
  logic [26:0]           next_tb_acc;
  logic [27:0]           tb_sum;
  logic [DIV_STAGES-1:0] div;
  logic [DIV_STAGES-1:0] next_div;
  logic                  tap_prev;
  logic                  next_tap_prev;
  rtcc_osc_e             osc_state;
  rtcc_osc_e             next_osc_state;
  logic                  update_pending_flag;
  logic                  next_update_pending_flag;
  rtcc_ctrl_a_s          ctrl_a;
  rtcc_ctrl_a_s          next_ctrl_a;
  rtcc_mode_s            mode;
  rtcc_mode_s            next_mode;
  logic                  periodic_flag;
  logic                  next_periodic_flag;
  logic                  alarm_flag;
  logic                  next_alarm_flag;
  logic                  update_done_flag;
  logic                  next_update_done_flag;
  logic                  next_irq_n;
  logic [7:0]            next_reg_rdata;
  logic                  next_square_wave_out;
  logic                  next_internal_update;
  logic                  next_user_copy_update;
  logic                  rst_s1;
  logic                  rst_s2;
  logic                  rst_s3;
  logic                  batt_s1;
  logic                  batt_s2;

  // ==========================================================================
  // decoded events
  logic       tick;
  logic       running;
  logic [3:0] tap_idx;
  logic       tap_now;
  logic       tap_event;
  logic       sec_tick;
  logic       alarm_match;
  logic [2:0] byte_match;
  logic       wr_a;
  logic       wr_b;
  logic       rd_c;
  logic       set_rise;
  logic       pin_rst;
  logic       pin_fall;
  logic       irq_summary_flag;

  assign running  = (osc_state == OSC_RUNNING);
  assign wr_a     = reg_wr && (reg_addr == REG_OSC_RATE);
  assign wr_b     = reg_wr && (reg_addr == REG_MODE);
  assign rd_c     = reg_rd && (reg_addr == REG_FLAGS);
  assign set_rise = wr_b && reg_wdata[7] && !mode.set_freeze;
  // pin edge is taken between the second and third stage only
  assign pin_rst  = !rst_s2;
  assign pin_fall = rst_s3 && !rst_s2;

  // rate code to divider stage; codes 1 and 2 repeat the rates of codes 8 and 9
  always_comb begin
    if (ctrl_a.rate == RATE_CODE_1) begin
      tap_idx = TAP_CODE_1; // R25
    end else if (ctrl_a.rate == RATE_CODE_2) begin
      tap_idx = TAP_CODE_2; // R25
    end else begin
      tap_idx = ctrl_a.rate - TAP_SHIFT; // R25
    end
  end

  assign tap_now  = (ctrl_a.rate != RATE_NONE) && div[tap_idx]; // R5
  assign tap_event = running && tap_now && !tap_prev; // R19
  assign sec_tick = tick && running && (div == DIV_LAST); // R26

  // wildcard bytes match anything
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_alarm
      assign byte_match[gi] = alarm_time[gi*8+ALARM_ANY_BIT] ||
                              (alarm_time[gi*8 +: 8] == cur_time[gi*8 +: 8]); // R10
    end
  endgenerate
  assign alarm_match = &byte_match;

  assign irq_summary_flag = (periodic_flag && mode.periodic_irq_enable) ||
                            (alarm_flag && mode.alarm_irq_enable) ||
                            (update_done_flag && mode.update_done_irq_enable); // R18

  // ==========================================================================
  // time base, divider chain, update pending
  // fractional accumulator gives an exact average 32.768 khz from the core clock
  always_comb begin
    tb_sum      = {1'b0, tb_acc} + 28'(TB_INC);
    tick        = 1'b0;
    next_tb_acc = tb_acc;
    if (osc_state != OSC_OFF) begin
      if (tb_sum >= 28'(CORE_HZ)) begin
        tick        = 1'b1;
        next_tb_acc = 27'(tb_sum - 28'(CORE_HZ));
      end else begin
        next_tb_acc = tb_sum[26:0];
      end
    end
    case (ctrl_a.osc)
      OSC_RUN_CODE: next_osc_state = OSC_RUNNING; // R3
      default: begin
        if (ctrl_a.osc[2:1] == OSC_HOLD_TOP) begin
          next_osc_state = OSC_HELD; // R3
        end else begin
          next_osc_state = OSC_OFF; // R3
        end
      end
    endcase
    // held at preset so the first wrap lands a half second after release
    next_div = DIV_PRESET; // R4
    if (running) begin
      next_div = tick ? DIV_STAGES'(div + 1'b1) : div;
    end
    next_tap_prev = running ? tap_now : 1'b0;
    next_update_pending_flag = update_pending_flag;
    if (wr_b && reg_wdata[7]) begin
      next_update_pending_flag = 1'b0; // R2
    end else if (sec_tick) begin
      next_update_pending_flag = 1'b0;
    end else if (tick && running && (div == DIV_PEND_AT) && !mode.set_freeze) begin
      next_update_pending_flag = 1'b1; // R1
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tb_acc              <= '0;
      div                 <= DIV_PRESET;
      tap_prev            <= 1'b0;
      osc_state           <= OSC_OFF;
      update_pending_flag <= 1'b0;
    end else begin
      tb_acc              <= next_tb_acc;
      div                 <= next_div;
      tap_prev            <= next_tap_prev;
      osc_state           <= next_osc_state;
      update_pending_flag <= next_update_pending_flag;
    end
  end

  // ==========================================================================
  // control registers
  always_comb begin
    next_ctrl_a = ctrl_a;
    next_mode   = mode;
    if (wr_a) begin
      next_ctrl_a.osc  = reg_wdata[OSC_LSB +: 3]; // R3
      next_ctrl_a.rate = reg_wdata[RATE_LSB +: 4]; // R6
    end
    if (wr_b) begin
      next_mode = rtcc_mode_s'(reg_wdata); // R8 R14 R15
    end
    if (set_rise) begin
      next_mode.update_done_irq_enable = 1'b0; // R12
    end
    // pin reset wins over a write in the same cycle
    if (pin_rst) begin
      next_mode.periodic_irq_enable = 1'b0; // R9
      next_mode.alarm_irq_enable    = 1'b0; // R11
      next_mode.square_wave_enable  = 1'b0; // R13
    end
    if (pin_fall) begin
      next_mode.update_done_irq_enable = 1'b0; // R12
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_a <= '0;
      mode   <= '0;
    end else begin
      ctrl_a <= next_ctrl_a;
      mode   <= next_mode;
    end
  end

  // ==========================================================================
  // flags and interrupt
  // an event in the cycle of a flag read survives the read
  always_comb begin
    next_periodic_flag    = tap_event || (periodic_flag && !rd_c); // R19 R24
    next_alarm_flag       = (sec_tick && alarm_match) || (alarm_flag && !rd_c); // R20
    next_update_done_flag = sec_tick || (update_done_flag && !rd_c); // R21
    if (pin_rst) begin
      next_periodic_flag    = 1'b0;
      next_alarm_flag       = 1'b0;
      next_update_done_flag = 1'b0;
    end
    next_irq_n = !((next_periodic_flag && next_mode.periodic_irq_enable) ||
                   (next_alarm_flag && next_mode.alarm_irq_enable) ||
                   (next_update_done_flag && next_mode.update_done_irq_enable)); // R24
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      periodic_flag    <= 1'b0;
      alarm_flag       <= 1'b0;
      update_done_flag <= 1'b0;
      irq_n            <= 1'b1;
    end else begin
      periodic_flag    <= next_periodic_flag;
      alarm_flag       <= next_alarm_flag;
      update_done_flag <= next_update_done_flag;
      irq_n            <= next_irq_n;
    end
  end

  // ==========================================================================
  // read data and outputs
  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      if (reg_addr == REG_OSC_RATE) begin
        next_reg_rdata = {update_pending_flag, ctrl_a.osc, ctrl_a.rate}; // R1 R6
      end else if (reg_addr == REG_MODE) begin
        next_reg_rdata = mode;
      end else if (reg_addr == REG_FLAGS) begin
        next_reg_rdata = {irq_summary_flag, periodic_flag, alarm_flag,
                          update_done_flag, FLAGS_UNUSED}; // R18 R22
      end else begin
        next_reg_rdata = {batt_s2, BATT_UNUSED}; // R22 R23 R27
      end
    end
    next_square_wave_out  = mode.square_wave_enable && running && tap_now; // R13
    next_internal_update  = sec_tick; // R26
    // transfer only with pending shown, so a low pending bit always has the lead
    next_user_copy_update = sec_tick && !mode.set_freeze && update_pending_flag; // R7 R1
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata        <= RDATA_RESET;
      square_wave_out  <= 1'b0;
      internal_update  <= 1'b0;
      user_copy_update <= 1'b0;
    end else begin
      reg_rdata        <= next_reg_rdata;
      square_wave_out  <= next_square_wave_out;
      internal_update  <= next_internal_update;
      user_copy_update <= next_user_copy_update;
    end
  end

  // the counters outside apply format and daylight saving jumps
  assign binary_format_sel      = mode.binary_format_sel; // R14
  assign hour_24_sel            = mode.hour_24_sel; // R15
  assign daylight_saving_enable = mode.daylight_saving_enable; // R16 R17

  // ==========================================================================
  // pin synchronisers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rst_s1  <= 1'b1;
      rst_s2  <= 1'b1;
      rst_s3  <= 1'b1;
      batt_s1 <= 1'b0;
      batt_s2 <= 1'b0;
    end else begin
      rst_s1  <= rst_pin_n;
      rst_s2  <= rst_s1;
      rst_s3  <= rst_s2;
      batt_s1 <= battery_good_pin;
      batt_s2 <= batt_s1;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  freeze_clears_pend_a: assert property ( // R2
    (wr_b && reg_wdata[7]) |=> !update_pending_flag)
    else $error("pending bit not cleared by freeze write");

  transfer_lead_a: assert property ( // R1
    user_copy_update |-> $past(update_pending_flag))
    else $error("transfer without pending bit");

  osc_hold_a: assert property ( // R3
    (!running && !$past(running)) |-> (div == DIV_PRESET))
    else $error("divider moved while not running");

  rate_none_low_a: assert property ( // R25
    (ctrl_a.rate == RATE_NONE) |=> !square_wave_out)
    else $error("square wave active with rate none");

  wave_disable_a: assert property ( // R13
    !mode.square_wave_enable |=> !square_wave_out)
    else $error("square wave active while disabled");

  irq_summary_a: assert property ( // R24
    irq_n == !irq_summary_flag)
    else $error("interrupt pin disagrees with summary");

  read_clears_a: assert property ( // R24
    (rd_c && !tap_event && !sec_tick) |=> !periodic_flag && !alarm_flag && !update_done_flag)
    else $error("flag read did not clear flags");

  periodic_set_a: assert property ( // R19
    (tap_event && !pin_rst) |=> periodic_flag)
    else $error("periodic flag missed tap edge");

  upd_enable_clear_a: assert property ( // R12
    set_rise |=> !mode.update_done_irq_enable)
    else $error("update enable survived freeze rise");

  pin_reset_a: assert property ( // R9 R11 R13
    pin_rst |=> !mode.periodic_irq_enable && !mode.alarm_irq_enable &&
                !mode.square_wave_enable && irq_n)
    else $error("pin reset did not clear enables");

  uf_set_a: assert property ( // R21
    (sec_tick && !pin_rst) |=> update_done_flag ##0 internal_update)
    else $error("update done flag not set");

  periodic_irq_c: cover property (tap_event && mode.periodic_irq_enable ##1 !irq_n);
  alarm_c: cover property (sec_tick && alarm_match ##1 alarm_flag);
  frozen_update_c: cover property (sec_tick && mode.set_freeze);
  read_clear_c: cover property (rd_c && periodic_flag ##1 !periodic_flag);

endmodule

// ---- testbench/rtcc_host_model.sv ----
// host processor model driving the register strobes
module rtcc_host_model
  import rtcc_pkg::*;
(
  input  wire logic       core_clk,
  output logic      [1:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_addr = REG_OSC_RATE;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // ==========================================================================
  // bus cycles: one strobe cycle each, never rd and wr together
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

// ---- testbench/rtcc_regs_test.sv ----
// self-checking bench for the rtc control and status registers
module rtcc_regs_test
  import rtcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // one divider tick per clock keeps a second at 32768 cycles
  localparam int unsigned INC   = 99999999;
  localparam int          LIMIT = 90000;

  logic       core_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       rst_pin_n = 1'b1;
  logic       battery_good_pin = 1'b1;
  rtcc_time_s cur_time = '0;
  rtcc_time_s alarm_time = '0;
  logic [1:0] reg_addr;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       irq_n;
  logic       square_wave_out;
  logic       internal_update;
  logic       user_copy_update;
  logic       binary_format_sel;
  logic       hour_24_sel;
  logic       daylight_saving_enable;
  int         n_errors = 0;
  int         checked = 0;
  int         cyc = 0;
  int         n_int = 0;
  int         n_usr = 0;
  int         t_int = 0;

  rtcc_regs #(.TB_INC(INC)) rtcc_regs_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rst_pin_n(rst_pin_n), .battery_good_pin(battery_good_pin),
    .cur_time(cur_time), .alarm_time(alarm_time), .irq_n(irq_n),
    .square_wave_out(square_wave_out), .internal_update(internal_update),
    .user_copy_update(user_copy_update), .binary_format_sel(binary_format_sel),
    .hour_24_sel(hour_24_sel), .daylight_saving_enable(daylight_saving_enable)
  );

  rtcc_host_model rtcc_host_model_i (
    .core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );

  always #5 core_clk = ~core_clk;

  // ==========================================================================
  // monitor and closing
  always @(negedge core_clk) begin
    cyc++;
    if (internal_update === 1'b1) begin
      n_int++;
      t_int = cyc;
    end
    if (user_copy_update === 1'b1) begin
      n_usr++;
    end
    if (cyc == LIMIT) begin
      n_errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ==========================================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    rtcc_host_model_i.wr(a, d);
  endtask

  task automatic rchk(input logic [1:0] a, input logic [7:0] e);
    logic [7:0] v;
    rtcc_host_model_i.rd(a, v);
    check(v, e);
  endtask

  task automatic pin_reset();
    @(posedge core_clk);
    rst_pin_n <= 1'b0;
    tick(5);
    @(posedge core_clk);
    rst_pin_n <= 1'b1;
    tick(4);
  endtask

  // rise-to-rise period of the square wave, in cycles
  task automatic meas(output int n);
    int i;
    tick(2);
    for (i = 0; i < 9000 && square_wave_out !== 1'b0; i++) tick(1);
    for (i = 0; i < 9000 && square_wave_out !== 1'b1; i++) tick(1);
    for (n = 0; n < 9000 && square_wave_out !== 1'b0; n++) tick(1);
    while (n < 9000 && square_wave_out !== 1'b1) begin
      n++;
      tick(1);
    end
  endtask

  task automatic quiet(output logic hi);
    hi = 1'b0;
    tick(3);
    repeat (40) begin
      hi = hi | square_wave_out;
      tick(1);
    end
  endtask

  task automatic poll(output int t);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < 20000 && v[UPD_PEND_BIT] !== 1'b1; i++) begin
      rtcc_host_model_i.rd(REG_OSC_RATE, v);
    end
    t = cyc;
  endtask

  // ==========================================================================
  // scenarios
  task automatic s_regs();
    tick(3);
    rchk(REG_OSC_RATE, 8'h00);
    rchk(REG_MODE, 8'h00);
    rchk(REG_BATTERY, 8'h80);
    wr(REG_BATTERY, 8'h7f);
    wr(REG_FLAGS, 8'h0f);
    wr(REG_OSC_RATE, 8'h80);
    rchk(REG_BATTERY, 8'h80);
    rchk(REG_FLAGS, 8'h00);
    rchk(REG_OSC_RATE, 8'h00);
    @(posedge core_clk);
    battery_good_pin <= 1'b0;
    tick(4);
    rchk(REG_BATTERY, 8'h00);
    @(posedge core_clk);
    battery_good_pin <= 1'b1;
    tick(4);
    $display("done registers");
  endtask

  task automatic s_mode();
    wr(REG_OSC_RATE, 8'h0b);
    wr(REG_MODE, 8'h7f);
    rchk(REG_MODE, 8'h7f);
    pin_reset();
    rchk(REG_MODE, 8'h07);
    rchk(REG_OSC_RATE, 8'h0b);
    check(8'({binary_format_sel, hour_24_sel, daylight_saving_enable}), 8'h07);
    wr(REG_MODE, 8'h96);
    rchk(REG_MODE, 8'h86);
    pin_reset();
    rchk(REG_MODE, 8'h86);
    check(8'({binary_format_sel, hour_24_sel, daylight_saving_enable}), 8'h06);
    $display("done mode");
  endtask

  task automatic s_rates();
    int   n;
    int   k;
    logic hi;
    wr(REG_MODE, 8'h08);
    for (int c = 1; c < 12; c++) begin
      wr(REG_OSC_RATE, 8'h20 | 8'(c));
      k = (c == 1) ? 6 : (c == 2) ? 7 : c - 2;
      meas(n);
      check(8'(n == (2 << k)), 8'h01);
    end
    wr(REG_OSC_RATE, 8'h20);
    quiet(hi);
    check(8'(hi), 8'h00);
    wr(REG_OSC_RATE, 8'h63);
    quiet(hi);
    check(8'(hi), 8'h00);
    wr(REG_OSC_RATE, 8'h23);
    wr(REG_MODE, 8'h00);
    quiet(hi);
    check(8'(hi), 8'h00);
    $display("done rates");
  endtask

  task automatic s_periodic();
    int i;
    wr(REG_MODE, 8'h40);
    wr(REG_OSC_RATE, 8'h23);
    for (i = 0; i < 50 && irq_n !== 1'b0; i++) tick(1);
    check(8'(irq_n), 8'h00);
    wr(REG_OSC_RATE, 8'h20);
    rchk(REG_FLAGS, 8'hc0);
    rchk(REG_FLAGS, 8'h00);
    check(8'(irq_n), 8'h01);
    wr(REG_MODE, 8'h00);
    wr(REG_OSC_RATE, 8'h23);
    tick(20);
    wr(REG_OSC_RATE, 8'h20);
    check(8'(irq_n), 8'h01);
    rchk(REG_FLAGS, 8'h40);
    $display("done periodic");
  endtask

  task automatic s_update();
    int t0;
    int tp;
    int tu;
    int i;
    int u0;
    // wildcard in every byte: alarm every second
    @(posedge core_clk);
    alarm_time <= '1;
    wr(REG_OSC_RATE, 8'h00);
    wr(REG_MODE, 8'h30);
    rchk(REG_FLAGS, 8'h00);
    wr(REG_OSC_RATE, 8'h20);
    t0 = cyc;
    u0 = n_int;
    poll(tp);
    for (i = 0; i < 100 && internal_update !== 1'b1; i++) tick(1);
    tu = cyc;
    check(8'(user_copy_update), 8'h01);
    check(8'(tu - tp >= 4 && tu - tp <= 10), 8'h01);
    check(8'(tu - t0 >= 16380 && tu - t0 <= 16395), 8'h01);
    tick(2);
    check(8'(irq_n), 8'h00);
    rchk(REG_FLAGS, 8'hb0);
    @(posedge core_clk);
    alarm_time <= rtcc_time_s'(24'h000001);
    wr(REG_MODE, 8'h10);
    poll(tp);
    i = n_usr;
    wr(REG_MODE, 8'h90);
    rchk(REG_OSC_RATE, 8'h20);
    tick(40);
    check(8'(n_int - u0), 8'h02);
    check(8'(n_usr - i), 8'h00);
    check(8'(t_int - tu >= 32764 && t_int - tu <= 32772), 8'h01);
    rchk(REG_MODE, 8'h80);
    rchk(REG_FLAGS, 8'h10);
    $display("done update");
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    s_regs();
    s_mode();
    s_rates();
    s_periodic();
    s_update();
    test_done();
  end
endmodule
